// ==== common/icu_slave_pkg.sv ====
package icu_slave_pkg;
  // Register offsets
  localparam logic [7:0] OFS_VECTOR_BASE = 8'h20;
  localparam logic [7:0] OFS_END_OF_SERVICE = 8'h22;
  localparam logic [7:0] OFS_SOURCE_MASK = 8'h28;
  localparam logic [7:0] OFS_PRIORITY_THRESHOLD = 8'h2A;
  localparam logic [7:0] OFS_IN_SERVICE = 8'h2C;
  localparam logic [7:0] OFS_PENDING_REQUEST = 8'h2E;
  localparam logic [7:0] OFS_SHARED_STATUS = 8'h30;
  localparam logic [7:0] OFS_TIMER0_CTRL = 8'h32;
  localparam logic [7:0] OFS_DMA0_CTRL = 8'h34;
  localparam logic [7:0] OFS_DMA1_CTRL = 8'h36;
  localparam logic [7:0] OFS_TIMER1_CTRL = 8'h38;
  localparam logic [7:0] OFS_TIMER2_CTRL = 8'h3A;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h40;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h42;

  // Low type codes per source
  localparam logic [2:0] CODE_TIMER0 = 3'h0;
  localparam logic [2:0] CODE_RESERVED = 3'h1;
  localparam logic [2:0] CODE_DMA0 = 3'h2;
  localparam logic [2:0] CODE_DMA1 = 3'h3;
  localparam logic [2:0] CODE_TIMER1 = 3'h4;
  localparam logic [2:0] CODE_TIMER2 = 3'h5;
  localparam int NUM_CODES = 6;

  // Field positions
  localparam int EOS_NONSPECIFIC_BIT = 15;
  localparam int STATUS_DMA_HALT_BIT = 15;
  localparam int CTRL_MASK_BIT = 3;
  localparam int EV_DELIVERED = 0;
  localparam int EV_SERVICE_DONE = 1;
  localparam int EV_REFUSED = 2;

  // Values after reset
  localparam logic [4:0] RST_VECTOR_BASE = 5'h00;
  localparam logic [5:0] RST_SOURCE_MASK = 6'h3F;
  localparam logic [2:0] RST_PRIORITY = 3'h7;
  localparam logic [2:0] RST_THRESHOLD = 3'h7;

  // Fixed upper type bits in master configuration
  localparam logic [4:0] MASTER_TYPE_BASE = 5'h01;

  // Response timing
  localparam int CLK_MHZ = 100;
  localparam int RESPONSE_CLOCKS = 55;
  localparam int NUM_PHASES = 14;
  localparam logic [3:0] PH_ACK1 = 4'h1;
  localparam logic [3:0] PH_ACK2 = 4'h3;
  localparam logic [3:0] PH_LAST = 4'hD;
  // Phase lengths in clocks, index 13 first, index 0 last
  localparam logic [NUM_PHASES-1:0][2:0] PHASE_LEN = {
    3'h5, 3'h4, 3'h4, 3'h3, 3'h4, 3'h4, 3'h4,
    3'h3, 3'h4, 3'h5, 3'h4, 3'h2, 3'h4, 3'h5};

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_RUN = 2'b10
  } seq_state_t;
endpackage

// ==== src/icu_slave_mode_cascade.sv ====
`timescale 1ns/1ps
module icu_slave_mode_cascade
  import icu_slave_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic masterConfig,
  input wire logic [7:0] addr,
  input wire logic [15:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [15:0] rdData,
  input wire logic timer0Event,
  input wire logic dma0Event,
  input wire logic dma1Event,
  input wire logic timer1Event,
  input wire logic timer2Event,
  input wire logic slaveSelect,
  output logic intRequest,
  output logic intAckCycle,
  output logic [3:0] busPhase,
  output logic [7:0] typeNumber,
  output logic typeValid,
  output logic handlerFetch,
  output logic irq
);
  import icu_slave_pkg::*;

  typedef struct packed {
    seq_state_t seq;
    logic [3:0] phase;
    logic [2:0] cnt;
    logic [4:0] vecBase;
    logic [5:0] srcMask;
    logic [17:0] prio;
    logic [2:0] thr;
    logic [5:0] isr;
    logic [5:0] irr;
    logic [2:0] tmrSts;
    logic dmaHalt;
    logic [2:0] evSts;
    logic [2:0] evMask;
    logic [15:0] rdData;
    logic [7:0] typeNumber;
    logic typeValid;
    logic fetch;
    logic [1:0] selSync;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Codes that name a real source; code 1 stays reserved
  localparam logic [5:0] VALID_CODES = 6'h3D;

  // Response phases, lengths from the package table:
  //   0 request presented, 5 clocks
  //   1 first acknowledge, 4 clocks
  //   2 idle, 2 clocks
  //   3 second acknowledge, 4 clocks
  //   4 idle, 5 clocks
  //   5 vector offset read, 4 clocks
  //   6 idle, 3 clocks
  //   7 vector segment read, 4 clocks
  //   8 idle, 4 clocks
  //   9 flags push, 4 clocks
  //   10 idle, 3 clocks
  //   11 segment push, 4 clocks
  //   12 pointer push, 4 clocks
  //   13 idle before handler fetch, 5 clocks

  // True for a code that names a real source
  function automatic logic codeValid(input logic [2:0] code);
    return (code <= CODE_TIMER2) && (code != CODE_RESERVED);
  endfunction

  // Sum of all phase lengths, one full response
  function automatic int phaseTotal();
    int total;
    total = 0;
    for (int i = 0; i < NUM_PHASES; i++) begin
      total += int'(PHASE_LEN[i]);
    end
    return total;
  endfunction

  // Refuse constants the sequencer cannot serve
  if (NUM_CODES != 6) begin : g_codeCountCheck
    $error("six source codes expected");
  end
  if (phaseTotal() != RESPONSE_CLOCKS) begin : g_phaseSumCheck
    $error("phase lengths do not add up to the response time");
  end
  if (PH_LAST != 4'(NUM_PHASES - 1)) begin : g_lastPhaseCheck
    $error("last phase index does not match the phase count");
  end

  // Highest eligible request: {valid, code}
  function automatic logic [3:0] pickSource(
    input logic [5:0] req,
    input logic [5:0] msk,
    input logic [17:0] pri,
    input logic [2:0] threshold,
    input logic [5:0] inSvc
  );
    logic [3:0] best;
    logic [3:0] top;
    logic [3:0] found;
    best = 4'h8;
    top = 4'h8;
    found = 4'h0;
    // Best priority still in service
    for (int i = 0; i < NUM_CODES; i++) begin
      if (inSvc[i] && ({1'b0, pri[i*3 +: 3]} < top)) begin
        top = {1'b0, pri[i*3 +: 3]};
      end
    end
    for (int i = 0; i < NUM_CODES; i++) begin
      // Lower value wins, lowest code on ties
      // reserved code never requests
      if (codeValid(3'(i)) && req[i] && !msk[i] && pri[i*3 +: 3] <= threshold
          && ({1'b0, pri[i*3 +: 3]} < top) && ({1'b0, pri[i*3 +: 3]} < best)) begin
        best = {1'b0, pri[i*3 +: 3]};
        found = {1'b1, 3'(i)};
      end
    end
    return found;
  endfunction

  // Control register read image for one source
  function automatic logic [15:0] ctrlImage(
    input logic [17:0] pri,
    input logic [5:0] msk,
    input int code
  );
    ctrlImage = 16'h0000;
    ctrlImage[2:0] = pri[code*3 +: 3];
    ctrlImage[CTRL_MASK_BIT] = msk[code];
  endfunction

  logic [3:0] pick;
  logic [5:0] srcEvents;
  logic [5:0] ctrlHit;

  assign pick = pickSource(state_reg.irr, state_reg.srcMask, state_reg.prio,
                           state_reg.thr, state_reg.isr);
  // Source events in code order; code 1 has no source
  assign srcEvents = {
    timer2Event, // Code 5
    timer1Event, // Code 4
    dma1Event, // Code 3
    dma0Event, // Code 2
    1'b0, // Code 1 reserved
    timer0Event // Code 0
  };
  // Control register hits in code order
  assign ctrlHit = {
    addr == OFS_TIMER2_CTRL,
    addr == OFS_TIMER1_CTRL,
    addr == OFS_DMA1_CTRL,
    addr == OFS_DMA0_CTRL,
    1'b0,
    addr == OFS_TIMER0_CTRL
  };

  always_comb begin
    logic [5:0] setIrr;
    logic [5:0] clrIsr;
    logic [2:0] evSet;
    logic [2:0] code;
    setIrr = srcEvents;
    clrIsr = 6'h00;
    evSet = 3'h0;
    code = wrData[2:0];
    state_next = state_reg;
    state_next.typeValid = 1'b0;
    state_next.fetch = 1'b0;
    state_next.selSync = {state_reg.selSync[0], slaveSelect};

    // Register writes
    if (wrStrobe) begin
      if (addr == OFS_VECTOR_BASE) begin
        if (!masterConfig) begin
          state_next.vecBase = wrData[7:3];
        end
      end else if (addr == OFS_END_OF_SERVICE) begin
        if (wrData[EOS_NONSPECIFIC_BIT]) begin
          evSet[EV_REFUSED] = 1'b1;
        end else if (codeValid(code)) begin
          clrIsr[code] = 1'b1;
          evSet[EV_SERVICE_DONE] = 1'b1;
        end
      end else if (addr == OFS_SOURCE_MASK) begin
        // Mask per source, reserved bit kept clear
        state_next.srcMask = wrData[5:0] & VALID_CODES;
      end else if (addr == OFS_PRIORITY_THRESHOLD) begin
        // same threshold layout in both configurations
        state_next.thr = wrData[2:0];
      end else if (addr == OFS_IN_SERVICE) begin
        // In-service bits written directly
        state_next.isr = wrData[5:0] & VALID_CODES;
      end else if (addr == OFS_PENDING_REQUEST) begin
        // Pending requests written directly
        state_next.irr = wrData[5:0] & VALID_CODES;
      end else if (addr == OFS_SHARED_STATUS) begin
        // DMA halt and per-timer pending bits
        state_next.dmaHalt = wrData[STATUS_DMA_HALT_BIT];
        state_next.tmrSts = wrData[2:0];
      end else if (|ctrlHit) begin
        for (int i = 0; i < NUM_CODES; i++) begin
          if (ctrlHit[i]) begin
            state_next.prio[i*3 +: 3] = wrData[2:0];
            state_next.srcMask[i] = wrData[CTRL_MASK_BIT];
          end
        end
      end else if (addr == OFS_EVENT_STATUS) begin
        // Write one to clear
        state_next.evSts = state_reg.evSts & ~wrData[2:0];
      end else if (addr == OFS_EVENT_MASK) begin
        // One masks the event
        state_next.evMask = wrData[2:0];
      end
    end

    // Service-done clears first, so a delivery in the same cycle wins
    state_next.isr = state_next.isr & ~clrIsr;

    // Response sequencer
    case (state_reg.seq)
      SEQ_IDLE: begin
        if (pick[3]) begin
          state_next.seq = SEQ_RUN;
          state_next.phase = 4'h0;
          state_next.cnt = PHASE_LEN[0] - 3'h1;
        end
      end
      SEQ_RUN: begin
        if (state_reg.cnt != 3'h0) begin
          state_next.cnt = state_reg.cnt - 3'h1;
        end else if (state_reg.phase == PH_LAST) begin
          state_next.seq = SEQ_IDLE;
          state_next.fetch = 1'b1;
        end else begin
          state_next.phase = state_reg.phase + 4'h1;
          state_next.cnt = PHASE_LEN[state_reg.phase + 4'h1] - 3'h1;
        end
        // type handed over at end of second acknowledge
        if (state_reg.phase == PH_ACK2 && state_reg.cnt == 3'h0
            && state_reg.selSync[1] && pick[3]) begin
          state_next.typeNumber = {masterConfig ? MASTER_TYPE_BASE
                                  : state_reg.vecBase, pick[2:0]};
          state_next.typeValid = 1'b1;
          state_next.isr[pick[2:0]] = 1'b1;
          setIrr[pick[2:0]] = 1'b0;
          state_next.irr[pick[2:0]] = 1'b0;
          evSet[EV_DELIVERED] = 1'b1;
          if (pick[2:0] == CODE_TIMER0) begin
            state_next.tmrSts[0] = 1'b0;
          end else if (pick[2:0] == CODE_TIMER1) begin
            state_next.tmrSts[1] = 1'b0;
          end else if (pick[2:0] == CODE_TIMER2) begin
            state_next.tmrSts[2] = 1'b0;
          end
        end
      end
      default: begin
        state_next.seq = SEQ_IDLE;
      end
    endcase

    // Source events win over clears, except the delivered code's pending bit, which the delivery clears
    state_next.irr = state_next.irr | (setIrr & VALID_CODES);
    state_next.tmrSts = state_next.tmrSts | {timer2Event, timer1Event, timer0Event};
    state_next.evSts = state_next.evSts | evSet;

    // Read data, valid the cycle after the strobe
    state_next.rdData = 16'h0000;
    if (rdStrobe) begin
      if (addr == OFS_VECTOR_BASE) begin
        // Vector base, low type bits read zero
        state_next.rdData = {8'h00, masterConfig ? MASTER_TYPE_BASE
                             : state_reg.vecBase, 3'h0};
      end else if (addr == OFS_SOURCE_MASK) begin
        // Source mask image
        state_next.rdData = {10'h000, state_reg.srcMask};
      end else if (addr == OFS_PRIORITY_THRESHOLD) begin
        // Threshold image
        state_next.rdData = {13'h0000, state_reg.thr};
      end else if (addr == OFS_IN_SERVICE) begin
        // In-service image
        state_next.rdData = {10'h000, state_reg.isr};
      end else if (addr == OFS_PENDING_REQUEST) begin
        // Pending request image
        state_next.rdData = {10'h000, state_reg.irr};
      end else if (addr == OFS_SHARED_STATUS) begin
        // DMA halt and timer pending image
        state_next.rdData = {state_reg.dmaHalt, 12'h000, state_reg.tmrSts};
      end else if (|ctrlHit) begin
        // Control image of the addressed source
        for (int i = 0; i < NUM_CODES; i++) begin
          if (ctrlHit[i]) begin
            state_next.rdData = ctrlImage(state_reg.prio, state_reg.srcMask, i);
          end
        end
      end else if (addr == OFS_EVENT_STATUS) begin
        // Event status image
        state_next.rdData = {13'h0000, state_reg.evSts};
      end else if (addr == OFS_EVENT_MASK) begin
        // Event mask image
        state_next.rdData = {13'h0000, state_reg.evMask};
      end
      // poll offsets and all others read zero
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // Clear all, then load the nonzero reset values
      state_reg <= '0;
      state_reg.seq <= SEQ_IDLE;
      state_reg.vecBase <= RST_VECTOR_BASE;
      state_reg.srcMask <= RST_SOURCE_MASK;
      state_reg.prio <= {NUM_CODES{RST_PRIORITY}};
      state_reg.thr <= RST_THRESHOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign rdData = state_reg.rdData;
  // Request level to the external master
  assign intRequest = pick[3];
  assign intAckCycle = (state_reg.seq == SEQ_RUN)
                       && (state_reg.phase == PH_ACK1 || state_reg.phase == PH_ACK2);
  // Phase number while running, zero when idle
  assign busPhase = (state_reg.seq == SEQ_RUN) ? state_reg.phase : 4'h0;
  // Delivered type and one-cycle pulses
  assign typeNumber = state_reg.typeNumber;
  assign typeValid = state_reg.typeValid;
  assign handlerFetch = state_reg.fetch;
  // Level interrupt from unmasked events
  assign irq = |(state_reg.evSts & ~state_reg.evMask);
endmodule

// ==== verif/cascade_master_model.sv ====
`timescale 1ns/1ps
// External master controller with its cascade decode, behavioural
module cascade_master_model #(
  parameter logic [2:0] SERVED_SLAVE = 3'h2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic intAckCycle,
  input wire logic [2:0] ownNumber,
  output logic slaveSelect
);
  logic ackPrev_reg;
  logic [1:0] nAck_reg;
  logic [2:0] cascadeAddressLines;
  // Count acknowledges, window closes after the second one
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ackPrev_reg <= 1'b0;
      nAck_reg <= 2'h0;
    end else begin
      ackPrev_reg <= intAckCycle;
      if (intAckCycle && !ackPrev_reg) begin
        nAck_reg <= nAck_reg + 2'h1;
      end else if (!intAckCycle && ackPrev_reg && nAck_reg == 2'h2) begin
        nAck_reg <= 2'h0;
      end
    end
  end
  // drive served address, inverse when released
  assign cascadeAddressLines = (intAckCycle || nAck_reg != 2'h0) ? SERVED_SLAVE : ~SERVED_SLAVE;
  assign slaveSelect = (cascadeAddressLines == ownNumber);
endmodule

// ==== verif/icu_slave_mode_cascade_tb.sv ====
`timescale 1ns/1ps
module icu_slave_mode_cascade_tb;
  import icu_slave_pkg::*;
  typedef struct {int src; logic [2:0] code;} row_t;
  logic clk, reset_n, masterConfig, wrStrobe, rdStrobe, slaveSelect;
  logic intRequest, intAckCycle, typeValid, handlerFetch, irq, seenTv, seenHf;
  logic [7:0] addr;
  logic [7:0] typeNumber;
  logic [15:0] wrData;
  logic [15:0] rdData;
  logic [4:0] evt;
  logic [3:0] busPhase;
  logic [2:0] ownNumber;
  int n_mismatch = 0;
  int cmp_count = 0;
  row_t rows [5] = '{'{0, CODE_TIMER0}, '{1, CODE_DMA0}, '{2, CODE_DMA1},
    '{3, CODE_TIMER1}, '{4, CODE_TIMER2}};
  icu_slave_mode_cascade dut (.clk(clk), .reset_n(reset_n), .masterConfig(masterConfig),
    .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .timer0Event(evt[0]), .dma0Event(evt[1]), .dma1Event(evt[2]), .timer1Event(evt[3]),
    .timer2Event(evt[4]), .slaveSelect(slaveSelect), .intRequest(intRequest),
    .intAckCycle(intAckCycle), .busPhase(busPhase), .typeNumber(typeNumber),
    .typeValid(typeValid), .handlerFetch(handlerFetch), .irq(irq));
  cascade_master_model partner (.clk(clk), .reset_n(reset_n), .intAckCycle(intAckCycle),
    .ownNumber(ownNumber), .slaveSelect(slaveSelect));
  // Free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    chk(rdData === exp, "register read");
  endtask
  task automatic deliver(input int i);
    int k;
    k = 0;
    @(posedge clk);
    evt <= 5'h01 << i;
    @(posedge clk);
    evt <= 5'h00;
    #1;
    while (typeValid !== 1'b1 && k < 200) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 200) begin
      n_mismatch++;
      $display("wrong value at %0t: no type delivered", $time);
      conclude();
    end
  endtask
  task automatic fetchCheck();
    repeat (40) @(posedge clk);
    #1;
    chk(handlerFetch === 1'b1, "handler fetch timing");
  endtask
  initial begin
    reset_n = 1'b0;
    masterConfig = 1'b0;
    addr = 8'h00;
    wrData = 16'h0000;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    evt = 5'h00;
    ownNumber = 3'h2;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rd(OFS_SOURCE_MASK, 16'h003F);
    chk(intRequest === 1'b0, "request after reset");
    rd(OFS_PRIORITY_THRESHOLD, 16'h0007);
    rd(8'h24, 16'h0000);
    rd(8'h26, 16'h0000);
    wr(OFS_VECTOR_BASE, 16'h00A8);
    wr(OFS_SOURCE_MASK, 16'h0000);
    wr(OFS_EVENT_MASK, 16'h0000);
    // Each source delivered, then cleared by its own code
    foreach (rows[r]) begin
      deliver(rows[r].src);
      chk(typeNumber === {5'h15, rows[r].code}, "type number");
      fetchCheck();
      wr(OFS_END_OF_SERVICE, {13'h0000, rows[r].code});
      rd(OFS_IN_SERVICE, 16'h0000);
    end
    // Non-specific command refused, raises the event
    deliver(1);
    fetchCheck();
    wr(OFS_EVENT_STATUS, 16'h0007);
    @(posedge clk);
    #1;
    chk(irq === 1'b0, "irq after clear");
    wr(OFS_END_OF_SERVICE, 16'h8000);
    rd(OFS_EVENT_STATUS, 16'h0004);
    chk(irq === 1'b1, "irq on refusal");
    rd(OFS_IN_SERVICE, 16'h0004);
    wr(OFS_END_OF_SERVICE, 16'h0002);
    rd(OFS_IN_SERVICE, 16'h0000);
    wr(OFS_EVENT_MASK, 16'h0007);
    @(posedge clk);
    #1;
    chk(irq === 1'b0, "irq masked");
    wr(OFS_EVENT_STATUS, 16'h0007);
    // Master configuration keeps fixed types
    masterConfig <= 1'b1;
    wr(OFS_VECTOR_BASE, 16'h00F8);
    deliver(3);
    chk(typeNumber === {MASTER_TYPE_BASE, CODE_TIMER1}, "master type");
    fetchCheck();
    wr(OFS_END_OF_SERVICE, 16'h0004);
    masterConfig <= 1'b0;
    // Not selected: no type, sequence still completes
    ownNumber <= 3'h3;
    seenTv = 1'b0;
    seenHf = 1'b0;
    @(posedge clk);
    evt <= 5'h10;
    @(posedge clk);
    evt <= 5'h00;
    repeat (70) begin
      @(posedge clk);
      #1;
      if (typeValid === 1'b1) seenTv = 1'b1;
      if (handlerFetch === 1'b1) seenHf = 1'b1;
    end
    chk(seenTv === 1'b0, "type while unselected");
    chk(seenHf === 1'b1, "sequence incomplete");
    chk(intRequest === 1'b1, "request left pending");
    rd(OFS_PENDING_REQUEST, 16'h0020);
    rd(OFS_SHARED_STATUS, 16'h0004);
    conclude();
  end
endmodule

// ==== verif/icu_slave_properties.sv ====
`timescale 1ns/1ps
module icu_slave_checker
  import icu_slave_pkg::*;
(
  input logic clk,
  input logic reset_n,
  input logic masterConfig,
  input logic [7:0] addr,
  input logic [15:0] wrData,
  input logic wrStrobe,
  input logic rdStrobe,
  input logic [15:0] rdData,
  input logic slaveSelect,
  input logic intAckCycle,
  input logic [3:0] busPhase,
  input logic [7:0] typeNumber,
  input logic typeValid,
  input logic handlerFetch
);
  import icu_slave_pkg::*;
  logic [4:0] baseSeen_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Tracks the programmed vector base
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      baseSeen_reg <= RST_VECTOR_BASE;
    end else if (wrStrobe && addr == OFS_VECTOR_BASE && !masterConfig) begin
      baseSeen_reg <= wrData[7:3];
    end
  end
  a_ack_length: assert property ($rose(intAckCycle) |-> intAckCycle[*4] ##1 !intAckCycle)
    else $error("acknowledge not four clocks");
  a_ack_gap: assert property ($fell(intAckCycle) && busPhase == 4'h2
    |-> (!intAckCycle)[*2] ##1 intAckCycle)
    else $error("acknowledge gap wrong");
  a_response_time: assert property ($rose(intAckCycle) && busPhase == PH_ACK1
    |-> ##50 handlerFetch)
    else $error("handler fetch late or early");
  a_fetch_phase: assert property (handlerFetch |-> $past(busPhase) == PH_LAST)
    else $error("fetch outside last phase");
  a_slave_base: assert property (typeValid && !masterConfig
    |-> typeNumber[7:3] == baseSeen_reg)
    else $error("upper type bits not from base");
  a_master_base: assert property (typeValid && masterConfig
    |-> typeNumber[7:3] == MASTER_TYPE_BASE)
    else $error("master type bits not fixed");
  a_type_code: assert property (typeValid |-> typeNumber[2:0] inside {3'h0, 3'h2, 3'h3, 3'h4, 3'h5})
    else $error("low type code invalid");
  a_type_select: assert property (typeValid
    |-> $past(busPhase) == PH_ACK2 && $past(slaveSelect, 3))
    else $error("type without selection");
  a_poll_absent: assert property ($past(rdStrobe) && ($past(addr) == 8'h24 || $past(addr) == 8'h26)
    |-> rdData == 16'h0000)
    else $error("poll register present");
endmodule
bind icu_slave_mode_cascade icu_slave_checker chk (.clk(clk), .reset_n(reset_n),
  .masterConfig(masterConfig), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
  .rdStrobe(rdStrobe), .rdData(rdData), .slaveSelect(slaveSelect), .intAckCycle(intAckCycle),
  .busPhase(busPhase), .typeNumber(typeNumber), .typeValid(typeValid),
  .handlerFetch(handlerFetch));
